/* reset_and_power_on_control.sv */
// reset and power-on sequencer for the small key-scan controller
// assumes pins already synchronous to pclk; reset pin is open drain
//
// Contract
// - low reset pin enters system reset
// - reset: oscillator stopped, output floats, input grounded
// - after release count cycles, fetch address zero
// - detector reset pulls reset pin low
// - clear counter, pointers, timer, flags
// - load port and control reset values
// - data memory undefined or retained
// - bad standby op causes internal reset
// - rotate op on zero nibble resets
// - stack over or underflow resets
// - detector follows supply against trip level
// - detector asserts after one ms low
// - wait stabilization after detector release
// - pin and detector combined by or
// - oscillator halts in reset and stop
`timescale 1ns/1ps
`default_nettype none
module reset_and_power_on_control
  import rst_ctrl_pkg::*;
#(
  parameter int WAIT_COUNT = WAIT_CYC,
  parameter int DIV_COUNT  = OSC_DIV,
  parameter int FILT_COUNT = DROP_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // reset pin, open drain
  input  wire logic        reset_pin_n_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  // supply comparator
  input  wire logic        supply_low,
  // key inputs
  input  wire logic [3:0]  key_input_pins,
  // oscillator pins
  output logic             osc_output_pin_out,
  output logic             osc_output_pin_oe,
  output logic             osc_input_pin_out,
  output logic             osc_input_pin_oe,
  // core side
  output logic             osc_enable,
  output logic             core_reset,
  output logic             fetch_start,
  output logic             warm_reset
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (WAIT_COUNT < WAIT_MIN_CYC || WAIT_COUNT > WAIT_MAX_CYC) begin : g_w
    $error("WAIT_COUNT outside the stabilization range");
  end
  if (DIV_COUNT < 1 || DIV_COUNT > 65535) begin : g_d
    $error("DIV_COUNT out of range");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    seq_state_t  st;        // sequencer state
    logic [6:0]  wcnt;      // oscillator cycles since release
    logic [15:0] div;       // pclk divider toward osc tick
    logic        det_en;    // detector fitted
    logic        stop_req;  // oscillator-off standby
    logic        standby;   // any standby mode active
    logic        fault;     // pending internal fault reset
    logic        warm;      // last reset hit during standby
    logic [9:0]  pc;        // program_counter image
    logic [7:0]  dp;        // data_pointer image
    logic [9:0]  timer;     // timer image
    logic        sp;        // stack_pointer image
    logic        stflag;    // standby_indicator image
    logic        cy;        // carry_bit image
    logic [7:0]  port0;     // key_io_port_low image
    logic [7:0]  ctrl3;     // ctrl_reg_three image
    logic [7:0]  ctrl4;     // ctrl_reg_four image
    logic [31:0] rdata;     // apb read data
    logic        ready;     // apb ready
    logic        err;       // apb error
    logic        pin_pull;  // drive reset pin low
    logic        osc_run;   // oscillator enable
    logic        gnd_in;    // oscillator input held at ground
    logic        creset;    // core reset out
    logic        fetch;     // start-fetch pulse
  } state_t;

  state_t cur;
  state_t next_cur;

  logic drop_reset;  // filtered detector reset
  logic osc_tick;    // one-cycle enable at oscillator rate
  logic any_reset;   // or of every source

  // supply-drop detector
  supply_drop_filter #(
    .FILT_CYC (FILT_COUNT)
  ) u_filter (
    .pclk       (pclk),
    .presetn    (presetn),
    .enable     (cur.det_en),
    .supply_low (supply_low),
    .drop_reset (drop_reset)
  );

  // decode of an address to a known register
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == ADDR_CTRL) || (a == ADDR_STATUS) ||
               (a == ADDR_CORE) || (a == ADDR_PORTS) ||
               (a == ADDR_FAULT);
  endfunction : addr_hit

  assign any_reset = !reset_pin_n_in || drop_reset || cur.fault;
  assign osc_tick  = (cur.div == 16'(DIV_COUNT - 1));

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_cur       = cur;
    next_cur.fetch = 1'b0;
    next_cur.ready = 1'b0;
    next_cur.err   = 1'b0;
    // divider only runs while the oscillator runs
    if (!cur.osc_run || osc_tick) begin
      next_cur.div = 16'h0000;
    end else begin
      next_cur.div = cur.div + 16'h0001;
    end

    // apb: one wait state, answer in access cycle
    if (psel && penable && !cur.ready) begin
      next_cur.ready = 1'b1;
      next_cur.err   = !addr_hit(paddr);
      next_cur.rdata = 32'h0000_0000;
      if (pwrite) begin
        unique case (paddr)
          ADDR_CTRL: begin
            next_cur.det_en   = pwdata[CTRL_DET_EN];
            next_cur.stop_req = pwdata[CTRL_STOP];
            next_cur.standby  = pwdata[CTRL_STANDBY];
          end
          ADDR_FAULT: begin
            if (pwdata[FLT_STANDBY] || pwdata[FLT_ROTATE] ||
                pwdata[FLT_STACK]) begin
              next_cur.fault = 1'b1;
            end
          end
          default: begin
            // read-only or unmapped: write ignored
          end
        endcase
      end else begin
        unique case (paddr)
          ADDR_CTRL: begin
            next_cur.rdata = {29'h0, cur.standby, cur.stop_req,
                              cur.det_en};
          end
          ADDR_STATUS: begin
            next_cur.rdata = {24'h0, 1'b0, cur.warm, drop_reset,
                              cur.pin_pull, cur.creset, cur.st};
          end
          ADDR_CORE: begin
            next_cur.rdata = {cur.cy, cur.stflag, cur.sp, 1'b0,
                              cur.dp, cur.timer, cur.pc};
          end
          ADDR_PORTS: begin
            // upper nibble of high port follows the key inputs
            next_cur.rdata = {key_input_pins, PORT1_LOW, cur.ctrl4,
                              cur.ctrl3, cur.port0};
          end
          default: begin
            next_cur.rdata = 32'h0000_0000;
          end
        endcase
      end
    end

    next_cur.pin_pull = drop_reset;

    // sequencer
    unique case (cur.st)
      ST_RESET: begin
        next_cur.osc_run = 1'b0;
        next_cur.creset  = 1'b1;
        next_cur.wcnt    = 7'h00;
        next_cur.fault   = 1'b0;
        if (!any_reset) begin
          next_cur.st      = ST_WAIT;
          next_cur.osc_run = 1'b1;
        end
      end
      ST_WAIT: begin
        if (any_reset) begin
          next_cur.st      = ST_RESET;
          next_cur.osc_run = 1'b0;
        end else if (osc_tick) begin
          if (cur.wcnt == 7'(WAIT_COUNT - 1)) begin
            next_cur.st     = ST_RUN;
            next_cur.creset = 1'b0;
            next_cur.fetch  = 1'b1;
          end else begin
            next_cur.wcnt = cur.wcnt + 7'h01;
          end
        end
      end
      ST_RUN: begin
        next_cur.osc_run = !cur.stop_req;
        if (any_reset) begin
          next_cur.st      = ST_RESET;
          next_cur.osc_run = 1'b0;
          next_cur.creset  = 1'b1;
          next_cur.warm    = cur.standby;
        end
      end
      default: begin
        next_cur.st = ST_RESET;
      end
    endcase

    if (any_reset) begin
      next_cur.pc       = PC_RESET;
      next_cur.dp       = DP_RESET;
      next_cur.timer    = TIMER_RESET;
      next_cur.sp       = SP_RESET;
      next_cur.stflag   = FLAG_RESET;
      next_cur.cy       = FLAG_RESET;
      next_cur.port0    = PORT0_RESET;
      next_cur.ctrl3    = CTRL3_RESET;
      next_cur.ctrl4    = CTRL4_RESET;
      next_cur.stop_req = 1'b0;
      next_cur.standby  = 1'b0;
    end
    // a fault arriving now outlives the clear above
    if (psel && penable && !cur.ready && pwrite &&
        paddr == ADDR_FAULT && pwdata[2:0] != 3'h0) begin
      next_cur.fault = 1'b1;
    end
    // ground input while stopped
    // own flop so the pin enable needs no gate after the register
    next_cur.gnd_in = !next_cur.osc_run;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur          <= '0;
      cur.st       <= ST_RESET;
      cur.det_en   <= CTRL_RESET[CTRL_DET_EN];
      cur.creset   <= 1'b1;
      cur.gnd_in   <= 1'b1;
      cur.port0    <= PORT0_RESET;
      cur.ctrl3    <= CTRL3_RESET;
      cur.ctrl4    <= CTRL4_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // ---------------------------------------------------------------
  // outputs, from flops except the pin data outputs, which are tied low
  // ---------------------------------------------------------------
  assign prdata             = cur.rdata;
  assign pready             = cur.ready;
  assign pslverr            = cur.err;
  assign reset_pin_out      = 1'b0;
  assign reset_pin_oe       = cur.pin_pull;
  assign osc_output_pin_out = 1'b0;
  assign osc_output_pin_oe  = cur.osc_run;
  assign osc_input_pin_out  = 1'b0;
  assign osc_input_pin_oe   = cur.gnd_in;
  assign osc_enable         = cur.osc_run;
  assign core_reset         = cur.creset;
  assign fetch_start        = cur.fetch;
  assign warm_reset         = cur.warm;

endmodule : reset_and_power_on_control
`default_nettype wire

/* reset_and_power_on_control_bench.sv */
// self-checking bench for the reset and power-on sequencer
// assumes the line model on the pin and the bound checker
`timescale 1ns/1ps
`default_nettype none
module reset_and_power_on_control_bench;
  import rst_ctrl_pkg::*;
  localparam int DIV  = 2;  // shortened oscillator divider
  localparam int FILT = 20; // shortened supply filter
  localparam int LO   = WAIT_CYC * DIV - 8; // earliest run, sync slack
  localparam int HI   = WAIT_CYC * DIV + 8; // latest run
  logic        pclk, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, ext_pull = 1'h0, supply_low = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, pin_n, rp_out, rp_oe, oo_oe, oi_oe, e;
  logic        osc_enable, core_reset, fetch_start, warm, oi_out;
  logic [3:0]  keys;
  int          err_total, comparisons, cyc, n;

  reset_and_power_on_control #(
    .WAIT_COUNT(WAIT_CYC), .DIV_COUNT(DIV), .FILT_COUNT(FILT)
  ) reset_and_power_on_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_pin_n_in(pin_n),
    .reset_pin_out(rp_out), .reset_pin_oe(rp_oe),
    .supply_low(supply_low), .key_input_pins(keys),
    .osc_output_pin_out(), .osc_output_pin_oe(oo_oe),
    .osc_input_pin_out(oi_out), .osc_input_pin_oe(oi_oe),
    .osc_enable(osc_enable), .core_reset(core_reset),
    .fetch_start(fetch_start), .warm_reset(warm)
  );
  reset_line_model reset_line_model_inst (
    .ext_pull(ext_pull), .dev_oe(rp_oe), .dev_out(rp_out),
    .pin_n(pin_n), .keys(keys)
  );

  // 125 MHz clock
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  // hang guard, far above the expected couple of thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer; result left in q and e
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // wait for the core to run, judging the stabilisation count
  task automatic wait_run;
    n = 0;
    while (core_reset !== 1'h0 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, n >= LO && n <= HI}, 32'h1);
  endtask : wait_run
  // reset images, then refused and read-only accesses
  task automatic t_boot;
    wait_run;
    apb(1'h0, ADDR_CORE, 32'h0);
    check(q, 32'h0);
    apb(1'h0, ADDR_PORTS, 32'h0);
    check(q, {4'hE, PORT1_LOW, CTRL4_RESET, CTRL3_RESET, PORT0_RESET});
    apb(1'h0, 8'h14, 32'h0);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
    apb(1'h1, ADDR_STATUS, 32'hFFFF_FFFF);
    apb(1'h0, ADDR_STATUS, 32'h0);
    check(q, 32'h4);
  endtask : t_boot
  // external circuit holds the pin low, then lets go
  task automatic t_pin;
    ext_pull <= 1'h1;
    repeat (6) @(posedge pclk);
    check({31'h0, core_reset}, 32'h1);
    check({29'h0, osc_enable, oo_oe, oi_oe}, 32'h1);
    check({31'h0, oi_out}, 32'h0);
    ext_pull <= 1'h0;
    wait_run;
  endtask : t_pin
  // short dip is ignored, long dip pulls the pin until recovery
  task automatic t_supply;
    supply_low <= 1'h1;
    repeat (FILT - 4) @(posedge pclk);
    supply_low <= 1'h0;
    check({30'h0, rp_oe, core_reset}, 32'h0);
    @(posedge pclk);
    supply_low <= 1'h1;
    repeat (FILT + 6) @(posedge pclk);
    check({29'h0, rp_oe, pin_n, core_reset}, 32'h5);
    supply_low <= 1'h0;
    repeat (3) @(posedge pclk);
    check({31'h0, rp_oe}, 32'h0);
    wait_run;
  endtask : t_supply
  // each fault source in turn
  task automatic t_fault;
    for (int i = 0; i < 3; i++) begin
      apb(1'h1, ADDR_FAULT, 32'h1 << i);
      repeat (3) @(posedge pclk);
      check({31'h0, core_reset}, 32'h1);
      wait_run;
    end
    apb(1'h0, ADDR_CORE, 32'h0);
    check(q, 32'h0);
  endtask : t_fault
  // stop standby halts the oscillator; a reset there is warm
  task automatic t_stop;
    apb(1'h1, ADDR_CTRL, 32'h7);
    repeat (4) @(posedge pclk);
    check({30'h0, osc_enable, core_reset}, 32'h0);
    t_pin;
    check({31'h0, warm}, 32'h1);
    apb(1'h0, ADDR_CTRL, 32'h0);
    check(q, CTRL_RESET);
    // detector option absent: a long dip must leave the core running
    apb(1'h1, ADDR_CTRL, 32'h0);
    supply_low <= 1'h1;
    repeat (FILT + 6) @(posedge pclk);
    check({30'h0, rp_oe, core_reset}, 32'h0);
    supply_low <= 1'h0;
    apb(1'h1, ADDR_CTRL, CTRL_RESET);
  endtask : t_stop

  task end_sim;
    $display("comparisons %0d, err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    t_boot;
    t_pin;
    t_supply;
    t_fault;
    t_stop;
    end_sim;
  end
endmodule : reset_and_power_on_control_bench
`default_nettype wire

/* reset_line_model.sv */
// far side of the reset pin: open-drain reset circuit and key pad
// assumes bench drives ext_pull off the clock edge; pin has a pull-up
`timescale 1ns/1ps
`default_nettype none
module reset_line_model (
  // drive requests
  input  wire logic       ext_pull,
  input  wire logic       dev_oe,
  input  wire logic       dev_out,
  // lines seen by the device
  output logic            pin_n,
  output logic [3:0]      keys
);
  // open-drain wired and
  // either party only pulls low; the pull-up wins when both let go
  assign pin_n = !(ext_pull || (dev_oe && !dev_out));
  // one key held low
  // key 0 grounded, so one key is low at every reset release
  assign keys = 4'hE;
endmodule : reset_line_model
`default_nettype wire

/* rst_ctrl_pkg.sv */
// constants and types for the reset and power-on controller
// assumes a single 125 MHz pclk domain; all counts derive from it
`default_nettype none
package rst_ctrl_pkg;

  // ---------------------------------------------------------------
  // apb register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00; // control
  localparam logic [7:0] ADDR_STATUS  = 8'h04; // status, read only
  localparam logic [7:0] ADDR_CORE    = 8'h08; // core reset image
  localparam logic [7:0] ADDR_PORTS   = 8'h0C; // port reset image
  localparam logic [7:0] ADDR_FAULT   = 8'h10; // fault event strobes

  // control field positions
  localparam int CTRL_DET_EN   = 0;  // supply-drop detector present
  localparam int CTRL_STOP     = 1;  // oscillator-off standby request
  localparam int CTRL_STANDBY  = 2;  // core in any standby mode

  // fault strobe field positions
  localparam int FLT_STANDBY   = 0;  // bad standby operand or precondition
  localparam int FLT_ROTATE    = 1;  // rotate_or_reset_op with zero nibble
  localparam int FLT_STACK     = 2;  // stack pointer over or underflow

  // control reset value: detector option fitted
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // ---------------------------------------------------------------
  // core reset values
  // ---------------------------------------------------------------
  localparam logic [9:0] PC_RESET     = 10'h000;
  localparam logic [7:0] DP_RESET     = 8'h00;
  localparam logic [9:0] TIMER_RESET  = 10'h000;
  localparam logic       SP_RESET     = 1'h0;
  localparam logic       FLAG_RESET   = 1'h0;
  localparam logic [7:0] PORT0_RESET  = 8'hFF;
  localparam logic [3:0] PORT1_LOW    = 4'hF;
  localparam logic [7:0] CTRL3_RESET  = 8'h03;
  localparam logic [7:0] CTRL4_RESET  = 8'h26;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int WAIT_MIN_CYC   = 60;   // least oscillator cycles
  localparam int WAIT_MAX_CYC   = 116;  // most oscillator cycles
  localparam int WAIT_CYC       = 88;   // chosen terminal count
  localparam int CLK_HZ         = 125_000_000;
  localparam int OSC_HZ         = 500_000;  // modelled oscillator rate
  localparam int OSC_DIV        = CLK_HZ / OSC_HZ; // pclk per osc tick
  localparam int DROP_TIME_US   = 1000;     // 1 ms supply-low filter
  localparam int DROP_CYC       = (DROP_TIME_US * (CLK_HZ / 1_000_000));

  // sequencer states
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,   // reset held, oscillator stopped
    ST_WAIT  = 3'b010,   // stabilization count
    ST_RUN   = 3'b100    // core running
  } seq_state_t;

endpackage : rst_ctrl_pkg
`default_nettype wire

/* rst_seq_asserts.sv */
// concurrent checks on the reset sequencer ports
// assumes one pclk domain; bound onto every sequencer instance
`timescale 1ns/1ps
`default_nettype none
module rst_seq_asserts
  import rst_ctrl_pkg::*;
#(
  parameter int WAIT_COUNT = WAIT_CYC,
  parameter int DIV_COUNT  = OSC_DIV,
  parameter int FILT_COUNT = DROP_CYC
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // reset pin and supply
  input wire logic        reset_pin_n_in,
  input wire logic        reset_pin_out,
  input wire logic        reset_pin_oe,
  input wire logic        supply_low,
  // oscillator and core side
  input wire logic        osc_output_pin_oe,
  input wire logic        osc_input_pin_oe,
  input wire logic        osc_enable,
  input wire logic        core_reset,
  input wire logic        fetch_start
);
  int wait_cyc; // pclks of running oscillator still in reset
  int low_cyc;  // pclks of supply low in a row
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // helper counts, zeroed when their condition drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cyc <= 0;
      low_cyc  <= 0;
    end else begin
      wait_cyc <= (core_reset && osc_enable) ? wait_cyc + 1 : 0;
      low_cyc  <= supply_low ? low_cyc + 1 : 0;
    end
  end

  property p_pin_in; !reset_pin_n_in |-> ##[1:2] core_reset; endproperty
  a_pin_in: assert property (p_pin_in)
    else $error("low pin left the core running");
  property p_osc_park;
    !reset_pin_n_in [*3] |-> !osc_enable && !osc_output_pin_oe
      && osc_input_pin_oe;
  endproperty
  a_osc_park: assert property (p_osc_park)
    else $error("oscillator pins not parked in reset");
  property p_wait_len;
    $fell(core_reset) |-> wait_cyc >= (WAIT_COUNT - 1) * DIV_COUNT
      && wait_cyc <= (WAIT_COUNT + 1) * DIV_COUNT;
  endproperty
  a_wait_len: assert property (p_wait_len)
    else $error("stabilisation count off");
  property p_fetch; $fell(core_reset) |-> ##[0:1] fetch_start; endproperty
  a_fetch: assert property (p_fetch)
    else $error("no fetch from address zero");
  property p_filter; $rose(reset_pin_oe) |-> low_cyc >= FILT_COUNT;
  endproperty
  a_filter: assert property (p_filter)
    else $error("supply drop not filtered");
  property p_release; $fell(supply_low) |-> ##[1:3] !reset_pin_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("detector kept pulling after recovery");
  property p_pull;
    reset_pin_oe [*2] |-> !reset_pin_out && core_reset;
  endproperty
  a_pull: assert property (p_pull)
    else $error("detector pull without low drive or reset");
  property p_ports;
    pready && psel && !pwrite && paddr == ADDR_PORTS
      |-> prdata[27:0] == 28'hF26_03FF;
  endproperty
  a_ports: assert property (p_ports)
    else $error("port reset image wrong");
  property p_fault;
    pready && psel && pwrite && paddr == ADDR_FAULT
      && pwdata[2:0] != 3'h0 |-> ##[0:3] core_reset;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault event did not reset");
endmodule : rst_seq_asserts

bind reset_and_power_on_control rst_seq_asserts #(
  .WAIT_COUNT(WAIT_COUNT), .DIV_COUNT(DIV_COUNT), .FILT_COUNT(FILT_COUNT)
) rst_seq_asserts_inst (.*);
`default_nettype wire

/* supply_drop_filter.sv */
// supply-drop detector filter: the comparator level must persist
// assumes comparator input already synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module supply_drop_filter
  import rst_ctrl_pkg::*;
#(
  parameter int FILT_CYC = DROP_CYC
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // detector
  input  wire logic enable,
  input  wire logic supply_low,
  output logic      drop_reset
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (FILT_CYC < 1) begin : g_bad
    $error("FILT_CYC must be at least one");
  end

  typedef struct packed {
    logic [31:0] cnt;    // cycles spent below trip level
    logic        active; // filtered reset
  } filt_t;

  filt_t cur;
  filt_t next_cur;

  // filter: assert after the full window, release at once
  always_comb begin
    next_cur = cur;
    if (!enable || !supply_low) begin
      next_cur.cnt    = 32'h0000_0000;
      next_cur.active = 1'b0;
    end else if (cur.cnt >= 32'(FILT_CYC - 1)) begin
      next_cur.active = 1'b1;
    end else begin
      next_cur.cnt = cur.cnt + 32'h0000_0001;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign drop_reset = cur.active;

endmodule : supply_drop_filter
`default_nettype wire
